//--- verilog/branch_pkg.sv
// holds the constants shared by the output branch scaler
// assumes values are signed tenths of a percent, gains in thousandths
package branch_pkg;
    localparam int NUM_CH = 4;
    localparam int SEL_W = 3;
    localparam int VAL_W = 16;
    localparam int GAIN_W = 16;
    // source-select code layout: code 0 disabled, codes 1, 4, 6 plain picks of ch1, ch2, ch3,
    // code 2 the one suppressed variant (ch1); self codes are 3 for ch2, 5 for ch3, 7 for ch4
    localparam logic [SEL_W-1:0] SEL_DISABLE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_CH1 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_CH1_SUPPRESS = 3'h2;
    localparam logic [SEL_W-1:0] SEL_CH2_SELF = 3'h3;
    localparam logic [SEL_W-1:0] SEL_CH3_SELF = 3'h5;
    localparam logic [SEL_W-1:0] SEL_CH3_CH2 = 3'h4;
    localparam logic [SEL_W-1:0] SEL_CH4_SELF = 3'h7;
    localparam logic [SEL_W-1:0] SEL_CH4_CH3 = 3'h6;
    localparam int GAIN_SCALE = 1000;
    localparam int GAIN_HALF = 500;
    localparam logic [VAL_W-1:0] ZERO_PCT = 16'h0000;
    localparam logic signed [VAL_W-1:0] DEFAULT_GAIN = 16'sh03E8;
endpackage

//--- verilog/output_branch_scaler.sv
// per-channel output branching: pick a source output, scale by gain, add bias
// assumes all inputs are synchronous to clk; tick marks one control cycle
`timescale 1ns/1ns

// How it works
// - branched output is source output times own gain plus own bias
// - branching only when standard control type is configured
// - branching only while channel runs under pid control
// - channel 2 codes: 0 off, 1 ch1, 2 ch1 suppressed, 3 self, 4-7 off
// - disabled select passes own controller output unscaled
// - plain source mode keeps own measured value and alarms live
// - suppressed mode zeroes measured value and probe-open flag, alarms off
// - self select scales own output with own gain and bias
// - higher-numbered channels are never accepted as source
// - channel 4 code 7 selects itself
// - manual mode uses own path without gain and bias
// - load rejection uses own path without gain and bias
// - disabled source forces zero output; disabled channel drives zero
// - stopped channel drives zero output
// - fallback value beats hand-set and fault values
module output_branch_scaler #(
    parameter int NUM_CH = branch_pkg::NUM_CH,
    parameter int VAL_W = branch_pkg::VAL_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic standardType,
    input wire logic [NUM_CH-1:0] pidMode,
    input wire logic [NUM_CH-1:0] chEnable,
    input wire logic [NUM_CH-1:0] chRun,
    input wire logic [NUM_CH-1:0] manualMode,
    input wire logic [NUM_CH-1:0] loadReject,
    input wire logic [NUM_CH-1:0] faultActive,
    input wire logic [NUM_CH*branch_pkg::SEL_W-1:0] branch_source_select,
    input wire logic [NUM_CH*branch_pkg::GAIN_W-1:0] branch_gain,
    input wire logic [NUM_CH*VAL_W-1:0] branch_bias,
    input wire logic [NUM_CH*VAL_W-1:0] controller_output_level,
    input wire logic [NUM_CH*VAL_W-1:0] hand_set_output,
    input wire logic [NUM_CH*VAL_W-1:0] fault_output_value,
    input wire logic [NUM_CH*VAL_W-1:0] fallback_output_value,
    input wire logic [NUM_CH*VAL_W-1:0] measuredIn,
    input wire logic [NUM_CH-1:0] probeOpenIn,
    output logic [NUM_CH*VAL_W-1:0] outputLevel,
    output logic [NUM_CH*VAL_W-1:0] measuredOut,
    output logic [NUM_CH-1:0] probeOpenOut,
    output logic [NUM_CH-1:0] measureActive,
    output logic [NUM_CH-1:0] branchActive,
    output logic done
);
    localparam int SW = branch_pkg::SEL_W;
    localparam int GW = branch_pkg::GAIN_W;
    localparam int PW = VAL_W + GW + 2;

    // ========================================
    // select decode
    // returns source channel index, or -1 when the code decodes as disabled
    function automatic int decodeSource(input int ch, input logic [SW-1:0] code);
        int src;
        src = -1;
        case (ch)
            1: begin
                if (code == branch_pkg::SEL_CH1 || code == branch_pkg::SEL_CH1_SUPPRESS) src = 0;
                else if (code == branch_pkg::SEL_CH2_SELF) src = 1;
            end
            2: begin
                if (code == branch_pkg::SEL_CH1 || code == branch_pkg::SEL_CH1_SUPPRESS) src = 0;
                else if (code == branch_pkg::SEL_CH3_CH2) src = 1;
                else if (code == branch_pkg::SEL_CH3_SELF) src = 2;
            end
            3: begin
                if (code == branch_pkg::SEL_CH1 || code == branch_pkg::SEL_CH1_SUPPRESS) src = 0;
                else if (code == branch_pkg::SEL_CH3_CH2) src = 1;
                else if (code == branch_pkg::SEL_CH4_CH3) src = 2;
                else if (code == branch_pkg::SEL_CH4_SELF) src = 3;
            end
            default: begin
                src = -1;
            end
        endcase
        // a source above the destination is refused whatever the code
        if (src > ch) src = -1;
        return src;
    endfunction

    // ========================================
    // scale with rounding to tenths
    function automatic logic [VAL_W-1:0] scale(input logic [VAL_W-1:0] v,
                                                input logic [GW-1:0] g,
                                                input logic [VAL_W-1:0] b);
        logic signed [PW-1:0] prod;
        logic signed [PW-1:0] q;
        prod = PW'($signed(v)) * PW'($signed(g));
        // round half away from zero so negative outputs are symmetric
        if (prod < 0) q = (prod - PW'(branch_pkg::GAIN_HALF)) / PW'(branch_pkg::GAIN_SCALE);
        else q = (prod + PW'(branch_pkg::GAIN_HALF)) / PW'(branch_pkg::GAIN_SCALE);
        q = q + PW'($signed(b));
        return q[VAL_W-1:0];
    endfunction

    // ========================================
    // branch gate
    // the gain and bias path needs a legal source, pid control and no override
    function automatic logic branchOn(input logic std,
                                      input logic pid,
                                      input logic hand,
                                      input logic reject,
                                      input int src);
        logic on;
        on = std && pid && (src >= 0);
        on = on && !hand && !reject;
        return on;
    endfunction

    // ========================================
    // own path, used whenever the gain and bias path is not
    function automatic logic [VAL_W-1:0] ownLevel(input logic reject,
                                                   input logic hand,
                                                   input logic fault,
                                                   input logic [VAL_W-1:0] fallVal,
                                                   input logic [VAL_W-1:0] handVal,
                                                   input logic [VAL_W-1:0] faultVal,
                                                   input logic [VAL_W-1:0] pidVal);
        logic [VAL_W-1:0] v;
        // fallback first, then hand-set, then fault, then pid
        if (reject) v = fallVal;
        else if (hand) v = handVal;
        else if (fault) v = faultVal;
        else v = pidVal;
        return v;
    endfunction

    logic [NUM_CH*VAL_W-1:0] next_outputLevel;
    logic [NUM_CH-1:0] next_branchActive;
    logic [NUM_CH*VAL_W-1:0] next_measuredOut;
    logic [NUM_CH-1:0] next_probeOpenOut;
    logic [NUM_CH-1:0] next_measureActive;
    logic next_done;

    // ========================================
    // per-channel output path
    always_comb begin
        int src;
        logic [VAL_W-1:0] own;
        logic [VAL_W-1:0] res;
        logic act;
        src = -1;
        own = branch_pkg::ZERO_PCT;
        res = branch_pkg::ZERO_PCT;
        act = 1'b0;
        next_outputLevel = outputLevel;
        next_branchActive = branchActive;
        if (tick) begin
            for (int c = 0; c < NUM_CH; c++) begin
                src = decodeSource(c, branch_source_select[c*SW +: SW]);
                own = ownLevel(loadReject[c], manualMode[c], faultActive[c],
                               fallback_output_value[c*VAL_W +: VAL_W],
                               hand_set_output[c*VAL_W +: VAL_W],
                               fault_output_value[c*VAL_W +: VAL_W],
                               controller_output_level[c*VAL_W +: VAL_W]);
                act = branchOn(standardType, pidMode[c], manualMode[c], loadReject[c], src);
                if (act) begin
                    // the source's raw pid result of this same cycle feeds the scaler
                    if (!chEnable[src]) res = branch_pkg::ZERO_PCT;
                    else res = scale(controller_output_level[src*VAL_W +: VAL_W],
                                     branch_gain[c*GW +: GW], branch_bias[c*VAL_W +: VAL_W]);
                end else begin
                    res = own;
                end
                if (!chEnable[c] || !chRun[c]) res = branch_pkg::ZERO_PCT;
                next_outputLevel[c*VAL_W +: VAL_W] = res;
                next_branchActive[c] = act && chEnable[c] && chRun[c];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outputLevel <= '0;
            branchActive <= '0;
        end else begin
            outputLevel <= next_outputLevel;
            branchActive <= next_branchActive;
        end
    end

    // ========================================
    // measured value path
    // blanking follows the branch gate, so an override brings the reading back
    always_comb begin
        int src;
        logic act;
        logic suppress;
        src = -1;
        act = 1'b0;
        suppress = 1'b0;
        next_measuredOut = measuredOut;
        next_probeOpenOut = probeOpenOut;
        next_measureActive = measureActive;
        if (tick) begin
            for (int c = 0; c < NUM_CH; c++) begin
                src = decodeSource(c, branch_source_select[c*SW +: SW]);
                act = branchOn(standardType, pidMode[c], manualMode[c], loadReject[c], src);
                suppress = act
                           && branch_source_select[c*SW +: SW] == branch_pkg::SEL_CH1_SUPPRESS;
                next_measureActive[c] = !suppress;
                if (suppress) begin
                    next_measuredOut[c*VAL_W +: VAL_W] = branch_pkg::ZERO_PCT;
                    next_probeOpenOut[c] = 1'b0;
                end else begin
                    next_measuredOut[c*VAL_W +: VAL_W] = measuredIn[c*VAL_W +: VAL_W];
                    next_probeOpenOut[c] = probeOpenIn[c];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            measuredOut <= '0;
            probeOpenOut <= '0;
            measureActive <= '1;
        end else begin
            measuredOut <= next_measuredOut;
            probeOpenOut <= next_probeOpenOut;
            measureActive <= next_measureActive;
        end
    end

    // ========================================
    // control-cycle strobe
    always_comb begin
        next_done = tick;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end
endmodule

//--- bench/branch_chk.sv
// port checks for the output branch scaler
// assumes one clock and the async active-low reset
`timescale 1ns/1ns
module branch_chk #(parameter int NUM_CH = 4, parameter int VAL_W = 16) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic standardType,
    input wire logic [NUM_CH-1:0] pidMode,
    input wire logic [NUM_CH-1:0] chEnable,
    input wire logic [NUM_CH-1:0] chRun,
    input wire logic [NUM_CH-1:0] manualMode,
    input wire logic [NUM_CH-1:0] loadReject,
    input wire logic [NUM_CH*branch_pkg::SEL_W-1:0] branch_source_select,
    input wire logic [NUM_CH*VAL_W-1:0] outputLevel,
    input wire logic [NUM_CH*VAL_W-1:0] measuredOut,
    input wire logic [NUM_CH-1:0] probeOpenOut,
    input wire logic [NUM_CH-1:0] measureActive,
    input wire logic [NUM_CH-1:0] branchActive,
    input wire logic done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // properties
    tick_done_a: assert property (tick |=> done) else $error("done missing");
    idle_hold_a: assert property (!tick |=> $stable(outputLevel) && !done)
        else $error("moved without tick");
    std_only_a: assert property (tick && !standardType |=> branchActive == 0)
        else $error("branch without standard type");
    pid_only_a: assert property (tick |=> (branchActive & ~$past(pidMode)) == 0)
        else $error("branch outside pid");
    own_path_a: assert property (
        tick |=> (branchActive & $past(manualMode | loadReject)) == 0) else $error("override lost");
    stop_zero_a: assert property (
        tick && !(chEnable[3] && chRun[3]) |=> outputLevel[63:48] == 0) else $error("not zero");
    suppress_a: assert property (tick && standardType && pidMode[2] && !manualMode[2]
        && !loadReject[2] && branch_source_select[8:6] == branch_pkg::SEL_CH1_SUPPRESS
        |=> measuredOut[47:32] == 0 && !probeOpenOut[2] && !measureActive[2])
        else $error("not blank");
    plain_off_a: assert property (tick && branch_source_select[5:3] == 3'h0 |=>
        !branchActive[1]) else $error("disabled code branched");
    ch1_never_a: assert property (tick |=> !branchActive[0]) else $error("ch1 branched");
endmodule
bind output_branch_scaler branch_chk #(.NUM_CH(NUM_CH), .VAL_W(VAL_W)) branch_chk_inst (
    .clk, .rst_b, .tick, .standardType, .pidMode, .chEnable, .chRun, .manualMode, .loadReject,
    .branch_source_select, .outputLevel, .measuredOut, .probeOpenOut, .measureActive,
    .branchActive, .done);

//--- bench/pid_source_model.sv
// per-channel controller outputs feeding the scaler
// assumes tick is the scaler's control-cycle strobe
`timescale 1ns/1ns
module pid_source_model (
    input wire logic clk,
    input wire logic tick,
    input wire logic [63:0] target,
    output logic [63:0] level
);
    // results move only between control cycles, so each tick sees one settled set
    always_ff @(posedge clk) if (!tick) level <= target;
endmodule

//--- bench/output_branch_scaler_tb.sv
// self-checking bench for the output branch scaler
// assumes the source model and the bound checker
`timescale 1ns/1ns
module output_branch_scaler_tb;
    logic clk, rst_b, tick, standardType, done;
    logic [3:0] pidMode, chEnable, chRun, manualMode, loadReject, faultActive, probe, pO, mA, bA;
    logic [11:0] sel;
    logic [63:0] gain, bias, target, ctl, hand, fault, fall, meas, outL, measO;
    int failures = 0;
    int samplesChecked = 0;
    int cycles = 0;
    pid_source_model pid_source_model_inst (.clk, .tick, .target, .level(ctl));
    output_branch_scaler output_branch_scaler_inst (.clk, .rst_b, .tick, .standardType,
        .pidMode, .chEnable, .chRun, .manualMode, .loadReject, .faultActive,
        .branch_source_select(sel), .branch_gain(gain), .branch_bias(bias),
        .controller_output_level(ctl), .hand_set_output(hand), .fault_output_value(fault),
        .fallback_output_value(fall), .measuredIn(meas), .probeOpenIn(probe), .outputLevel(outL),
        .measuredOut(measO), .probeOpenOut(pO), .measureActive(mA), .branchActive(bA), .done);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==========
    // tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic outs(input logic [63:0] e);
        for (int c = 0; c < 4; c++) check(outL[c*16 +: 16], e[c*16 +: 16]);
    endtask
    task automatic run_tick();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        @(negedge clk);
        check(16'(done), 16'h0001);
    endtask
    task automatic report_and_stop();
        $display("checked %0d, mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a hang counts as a mismatch; the whole run needs under 100 cycles
    always @(posedge clk) if (++cycles == 500) begin
        failures++;
        report_and_stop();
    end
    // ==========
    // sequence
    initial begin
        rst_b = 1'b0; tick = 1'b0; standardType = 1'b1; pidMode = 4'hF; chEnable = 4'hF;
        chRun = 4'hF; manualMode = 4'h0; loadReject = 4'h0; faultActive = 4'h0; probe = 4'hF;
        sel = {3'h7, 3'h2, 3'h1, 3'h0};
        gain = 64'h02BC_0320_0384_03E8;
        bias = 64'h012C_00C8_0064_0000;
        target = 64'h0258_00DE_006F_01F4;
        hand = {4{16'h0041}}; fault = {4{16'h0042}}; fall = {4{16'h0043}}; meas = {4{16'h0123}};
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        run_tick();
        outs(64'h02D0_0258_0226_01F4);
        check(measO[31:16], 16'h0123);
        check(measO[47:32] | 16'({mA[2], pO[2]}), 16'h0000);
        check(16'(bA), 16'h000E);
        @(posedge clk) chEnable <= 4'h6;
        run_tick();
        outs(64'h0);
        @(posedge clk) {chEnable, chRun} <= 8'hF5;
        run_tick();
        outs(64'h0000_0258_0000_01F4);
        @(posedge clk) {chRun, manualMode, loadReject, faultActive} <= 16'hF644;
        run_tick();
        outs(64'h02D0_0043_0041_01F4);
        @(posedge clk) {standardType, manualMode, loadReject, faultActive} <= 13'h0;
        run_tick();
        outs(64'h0258_00DE_006F_01F4);
        // ch1 at -0.5 rounds -4.5 and -4.0 away from zero
        @(posedge clk) {standardType, pidMode, target[15:0]} <= {5'h17, 16'hFFFB};
        run_tick();
        outs(64'h0258_00C4_005F_FFFB);
        for (int k = 4; k < 9; k++) begin
            @(posedge clk) {pidMode, sel} <= {4'hF, 3'h7, 3'h2, 3'(k), 3'h3};
            run_tick();
            check(outL[31:16], 16'h006F);
            check(outL[15:0], 16'hFFFB);
        end
        report_and_stop();
    end
endmodule
